// ---- design/vad_regs.sv ----
`timescale 1ns/1ps
module vad_regs #(
	parameter int GPO_SRC_W = 32 // general output source count
) (
	input wire logic clk,
	input wire logic rst,
	// register access from the serial control port, same clock
	input wire logic [4:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [23:0] reg_wdata,
	input wire logic reg_rd,
	output logic [23:0] reg_rdata,
	// autocalibration engine state
	input wire logic [7:0] cal_tune_curve,
	input wire logic cal_busy,
	input wire logic [18:0] cal_err_mag,
	input wire logic cal_err_sign,
	// general output sources and lock detect
	input wire logic [GPO_SRC_W-1:0] gpo_sources,
	input wire logic lock_detect,
	// auxiliary serial engine and pin control
	input wire logic aux_spi_sck,
	input wire logic aux_spi_cs,
	input wire logic aux_spi_dout,
	input wire logic aux_enable,
	input wire logic exact_freq_mode,
	input wire logic chip_en_pin,
	output logic [2:0] aux_out,
	output logic [2:0] aux_oe,
	output logic aux_3v3_sel,
	output logic phase_sync_trig,
	output logic gpo_out,
	// vco and output stage controls
	output logic manual_cal_en,
	output logic manual_tune_en,
	output logic [4:0] cap_switch,
	output logic [2:0] vco_subband,
	output logic cp_autoscale,
	output logic out_mute,
	output logic [5:0] out_div_ratio,
	output logic [1:0] lo1_gain,
	output logic [1:0] lo2_gain,
	output logic [3:0] lo1_atten_db,
	output logic [3:0] lo2_atten_db,
	output logic div_stage_max_gain
);

	// the select field is five bits, so at most 32 sources
	if (GPO_SRC_W < 2 || GPO_SRC_W > 32) begin : g_chk
		$error("vad_regs: GPO_SRC_W must be 2 to 32");
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------

	// attenuation below max gain for a two-bit buffer gain code
	function automatic logic [3:0] gain_atten(input logic [1:0] code);
		logic [3:0] steps;
		steps = {2'b00, 2'b11 - code};
		gain_atten = 4'(steps * vad_pkg::GAIN_STEP_DB);
	endfunction

	// ----------------------------------------------------------------
	// writable registers
	// ----------------------------------------------------------------
	logic [23:0] gpo_sel_r; // general output select
	logic [23:0] aux_r; // aux_port_control
	logic [23:0] manvco_r; // manual_vco_config
	logic [23:0] divgain_r; // output_divider_gain
	logic [23:0] next_gpo_sel_r;
	logic [23:0] next_aux_r;
	logic [23:0] next_manvco_r;
	logic [23:0] next_divgain_r;

	// full-word writes; read-only indices have no branch here
	always_comb begin
		next_gpo_sel_r = gpo_sel_r;
		next_aux_r = aux_r;
		next_manvco_r = manvco_r;
		next_divgain_r = divgain_r;
		if (reg_wr) begin
			unique case (reg_addr)
				vad_pkg::A_GPO_SEL: next_gpo_sel_r = reg_wdata;
				vad_pkg::A_AUX: next_aux_r = reg_wdata;
				vad_pkg::A_MANVCO: next_manvco_r = reg_wdata;
				vad_pkg::A_DIVGAIN: next_divgain_r = reg_wdata;
				default: begin
					// read-only or unmapped: dropped silently
					next_aux_r = aux_r;
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			gpo_sel_r <= vad_pkg::RST_GPO_SEL;
			aux_r <= vad_pkg::RST_AUX;
			manvco_r <= vad_pkg::RST_MANVCO;
			divgain_r <= vad_pkg::RST_DIVGAIN;
		end else begin
			gpo_sel_r <= next_gpo_sel_r;
			aux_r <= next_aux_r;
			manvco_r <= next_manvco_r;
			divgain_r <= next_divgain_r;
		end
	end

	// ----------------------------------------------------------------
	// internal state snapshots for readback
	// ----------------------------------------------------------------
	logic [23:0] tune_r; // vco_tune_status image
	logic [23:0] calerr_r; // calibration_error_readback image
	logic [1:0] lockrb_r; // general output and lock image
	logic [23:0] next_tune_r;
	logic [23:0] next_calerr_r;
	logic [1:0] next_lockrb_r;
	logic [4:0] gpo_sel; // selected source index
	logic gpo_mux; // selected general output

	// sampling every cycle keeps a multi-bit read coherent
	always_comb begin
		gpo_sel = gpo_sel_r[vad_pkg::GPO_SEL_LO +: 5];
		gpo_mux = 1'b0;
		if (32'(gpo_sel) < GPO_SRC_W) begin
			gpo_mux = gpo_sources[gpo_sel];
		end
		next_tune_r = 24'h00_0000;
		next_tune_r[vad_pkg::TUNE_CURVE_LO +: 8] = cal_tune_curve;
		next_tune_r[vad_pkg::TUNE_BUSY_BIT] = cal_busy;
		next_calerr_r = 24'h00_0000;
		next_calerr_r[vad_pkg::CAL_MAG_LO +: 19] = cal_err_mag;
		next_calerr_r[vad_pkg::CAL_SIGN_BIT] = cal_err_sign;
		next_lockrb_r = 2'b00;
		next_lockrb_r[vad_pkg::RB_GPO_BIT] = gpo_mux;
		next_lockrb_r[vad_pkg::RB_LOCK_BIT] = lock_detect;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tune_r <= vad_pkg::RST_TUNE;
			calerr_r <= vad_pkg::RST_CALERR;
			lockrb_r <= 2'b00;
		end else begin
			tune_r <= next_tune_r;
			calerr_r <= next_calerr_r;
			lockrb_r <= next_lockrb_r;
		end
	end

	// ----------------------------------------------------------------
	// read data
	// ----------------------------------------------------------------
	logic [23:0] next_reg_rdata; // word for the next cycle

	// unmapped indices read as zero; data holds until next read
	always_comb begin
		next_reg_rdata = reg_rdata;
		if (reg_rd) begin
			unique case (reg_addr)
				vad_pkg::A_GPO_SEL: next_reg_rdata = gpo_sel_r;
				vad_pkg::A_TUNE: next_reg_rdata = tune_r;
				vad_pkg::A_CALERR: next_reg_rdata = calerr_r;
				vad_pkg::A_LOCKRB: begin
					next_reg_rdata = vad_pkg::RST_LOCK_RSVD | {22'h0, lockrb_r};
				end
				vad_pkg::A_BUILTIN_TEST: next_reg_rdata = vad_pkg::RST_BUILTIN_TEST;
				vad_pkg::A_AUX: next_reg_rdata = aux_r;
				vad_pkg::A_MANVCO: next_reg_rdata = manvco_r;
				vad_pkg::A_DIVGAIN: next_reg_rdata = divgain_r;
				default: next_reg_rdata = 24'h00_0000;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 24'h00_0000;
		end else begin
			reg_rdata <= next_reg_rdata;
		end
	end

	// ----------------------------------------------------------------
	// phase sync trigger from the chip enable pin
	// ----------------------------------------------------------------
	logic [2:0] en_sync; // [0],[1] synchroniser, [2] edge history
	logic [2:0] next_en_sync;
	logic [2:0] en_fill; // ones shift in as the stages take real samples
	logic [2:0] next_en_fill;
	logic next_phase_sync_trig;
	logic next_gpo_out;

	// the pin is asynchronous; only stage 1 and 2 feed the edge
	always_comb begin
		next_en_sync = {en_sync[1:0], chip_en_pin};
		next_en_fill = {en_fill[1:0], 1'b1};
		// a rising enable edge fires only with exact mode on; a pin that
		// is already high at reset release is not an edge, so the history
		// stage must hold a real sample first
		next_phase_sync_trig = en_sync[1] && !en_sync[2] && en_fill[2]
			&& aux_r[vad_pkg::AUX_SYNC_BIT] && exact_freq_mode;
		next_gpo_out = gpo_mux;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			en_sync <= 3'b000;
			en_fill <= 3'b000;
			phase_sync_trig <= 1'b0;
			gpo_out <= 1'b0;
		end else begin
			en_sync <= next_en_sync;
			en_fill <= next_en_fill;
			phase_sync_trig <= next_phase_sync_trig;
			gpo_out <= next_gpo_out;
		end
	end

	// ----------------------------------------------------------------
	// field outputs from flops; the attenuation outputs are decoded from the gain codes
	// ----------------------------------------------------------------
	assign aux_3v3_sel = aux_r[vad_pkg::AUX_LVL_BIT];
	assign manual_cal_en = manvco_r[vad_pkg::MAN_CAL_BIT];
	assign cap_switch = manvco_r[vad_pkg::MAN_CAP_LO +: 5];
	assign vco_subband = manvco_r[vad_pkg::MAN_SUB_LO +: 3];
	// core consumes cap and sub-band only while this is high
	assign manual_tune_en = manvco_r[vad_pkg::MAN_TUNE_BIT];
	assign cp_autoscale = manvco_r[vad_pkg::MAN_AUTOCP_BIT];
	assign lo1_gain = divgain_r[vad_pkg::LO1_GAIN_LO +: 2];
	assign lo2_gain = divgain_r[vad_pkg::LO2_GAIN_LO +: 2];
	assign lo1_atten_db = gain_atten(lo1_gain);
	assign lo2_atten_db = gain_atten(lo2_gain);
	assign div_stage_max_gain = divgain_r[vad_pkg::DIV_STAGE_BIT];

	// ----------------------------------------------------------------
	// sub-blocks
	// ----------------------------------------------------------------
	vad_aux_drive u_aux (
		.clk(clk),
		.rst(rst),
		.aux_enable(aux_enable),
		.serial_mode(aux_r[vad_pkg::AUX_MODE_BIT]),
		.static_vals(aux_r[vad_pkg::AUX_VAL_LO +: 3]),
		.route(aux_r[vad_pkg::AUX_ROUTE_LO +: 2]),
		.idle_mode(aux_r[vad_pkg::AUX_IDLE_LO +: 2]),
		.general_output_mux(gpo_out),
		.spi_sck(aux_spi_sck),
		.spi_cs(aux_spi_cs),
		.spi_dout(aux_spi_dout),
		.aux_out(aux_out),
		.aux_oe(aux_oe)
	);

	vad_div_decode #(
		.RATIO_W(6)
	) u_div (
		.clk(clk),
		.rst(rst),
		.div_code(divgain_r[vad_pkg::DIV_RATIO_LO +: 6]),
		.div_ratio(out_div_ratio),
		.out_mute(out_mute)
	);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_tune_busy_read: assert property (@(posedge clk) disable iff (rst)
		(reg_rd && reg_addr == 5'h10 && !$past(rst, 2))
		|=> (reg_rdata[8] == $past(cal_busy, 2)))
		else $error("busy flag readback wrong");
	a_cal_sign_read: assert property (@(posedge clk) disable iff (rst)
		(reg_rd && reg_addr == 5'h11 && !$past(rst, 2))
		|=> (reg_rdata[19] == $past(cal_err_sign, 2)
			&& reg_rdata[23:20] == 4'h0))
		else $error("calibration sign readback wrong");
	a_lock_rb_read: assert property (@(posedge clk) disable iff (rst)
		(reg_rd && reg_addr == 5'h12 && !$past(rst, 2))
		|=> (reg_rdata[1] == $past(lock_detect, 2)))
		else $error("lock readback wrong");
	a_ro_write_drop: assert property (@(posedge clk) disable iff (rst)
		(reg_rd && reg_addr == vad_pkg::A_BUILTIN_TEST)
		|=> (reg_rdata == vad_pkg::RST_BUILTIN_TEST))
		else $error("read-only register took a write");
	a_sync_needs_exact: assert property (@(posedge clk) disable iff (rst)
		phase_sync_trig |-> ($past(exact_freq_mode)
			&& $past(aux_r[9]) && $past(en_sync[1], 1)))
		else $error("phase sync fired without its conditions");

endmodule // vad_regs

// ---- pkg/vad_pkg.sv ----
// ----------------------------------------------------------------
// register map, reset values and field positions
// ----------------------------------------------------------------
package vad_pkg;

	localparam int REG_W = 24; // every register is 24 bits wide
	localparam int ADDR_W = 5; // register index width

	// register indices on the serial control port
	localparam logic [4:0] A_GPO_SEL = 5'h0F; // general output select
	localparam logic [4:0] A_TUNE = 5'h10; // vco_tune_status
	localparam logic [4:0] A_CALERR = 5'h11; // calibration_error_readback
	localparam logic [4:0] A_LOCKRB = 5'h12; // output_lock_readback
	localparam logic [4:0] A_BUILTIN_TEST = 5'h13; // builtin_test_readback
	localparam logic [4:0] A_AUX = 5'h14; // aux_port_control
	localparam logic [4:0] A_MANVCO = 5'h15; // manual_vco_config
	localparam logic [4:0] A_DIVGAIN = 5'h16; // output_divider_gain

	// reset values
	localparam logic [23:0] RST_GPO_SEL = 24'h00_0001;
	localparam logic [23:0] RST_TUNE = 24'h00_0080;
	localparam logic [23:0] RST_CALERR = 24'h07_FFFF;
	localparam logic [23:0] RST_LOCK_RSVD = 24'h00_001C;
	localparam logic [23:0] RST_BUILTIN_TEST = 24'h00_1259;
	localparam logic [23:0] RST_AUX = 24'h00_0220;
	localparam logic [23:0] RST_MANVCO = 24'h0F_48A0;
	localparam logic [23:0] RST_DIVGAIN = 24'h00_06C1;

	// field positions
	localparam int GPO_SEL_LO = 0;
	localparam int TUNE_CURVE_LO = 0;
	localparam int TUNE_BUSY_BIT = 8;
	localparam int CAL_MAG_LO = 0;
	localparam int CAL_SIGN_BIT = 19;
	localparam int RB_GPO_BIT = 0;
	localparam int RB_LOCK_BIT = 1;
	localparam int AUX_MODE_BIT = 0;
	localparam int AUX_VAL_LO = 1;
	localparam int AUX_LVL_BIT = 4;
	localparam int AUX_SYNC_BIT = 9;
	localparam int AUX_ROUTE_LO = 10;
	localparam int AUX_IDLE_LO = 12;
	localparam int MAN_CAL_BIT = 0;
	localparam int MAN_CAP_LO = 1;
	localparam int MAN_SUB_LO = 6;
	localparam int MAN_TUNE_BIT = 9;
	localparam int MAN_AUTOCP_BIT = 16;
	localparam int DIV_RATIO_LO = 0;
	localparam int LO1_GAIN_LO = 6;
	localparam int LO2_GAIN_LO = 8;
	localparam int DIV_STAGE_BIT = 10;

	// divider limits and buffer gain step
	localparam logic [5:0] DIV_MUTE = 6'h00;
	localparam logic [5:0] DIV_MAX = 6'h3E;
	localparam logic [3:0] GAIN_STEP_DB = 4'h3;

	// drive of the auxiliary outputs while they are disabled
	typedef enum logic [1:0] {
		IDLE_HIZ = 2'b00,
		IDLE_KEEP = 2'b01,
		IDLE_HIGH = 2'b10,
		IDLE_LOW = 2'b11
	} vad_idle_t;

endpackage

// ---- design/vad_div_decode.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------
// output divide code to effective ratio, registered
// ----------------------------------------------------------------
module vad_div_decode #(
	parameter int RATIO_W = 6
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [RATIO_W-1:0] div_code,
	output logic [RATIO_W-1:0] div_ratio,
	output logic out_mute
);

	// the limit constant is six bits wide
	if (RATIO_W != 6) begin : g_chk
		$error("vad_div_decode: RATIO_W must be 6");
	end

	logic [RATIO_W-1:0] next_div_ratio; // effective divide
	logic next_out_mute; // output stages off

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	always_comb begin
		next_out_mute = 1'b0;
		next_div_ratio = div_code;
		if (div_code == vad_pkg::DIV_MUTE) begin
			// vco and pll buffer stay on, only output stages mute
			next_out_mute = 1'b1;
		end else if (div_code > vad_pkg::DIV_MAX) begin
			next_div_ratio = vad_pkg::DIV_MAX;
		end else if (div_code[0] && div_code != 6'h01) begin
			// odd codes above one fall to the even ratio below
			next_div_ratio = {div_code[RATIO_W-1:1], 1'b0};
		end
	end

	// register so the ratio never glitches between codes
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			div_ratio <= 6'h01;
			out_mute <= 1'b0;
		end else begin
			div_ratio <= next_div_ratio;
			out_mute <= next_out_mute;
		end
	end

	a_div_clamp_max: assert property (@(posedge clk) disable iff (rst)
		(div_code > 6'h3E) |=> (div_ratio == 6'h3E))
		else $error("divide above limit not clamped");
	a_div_odd_down: assert property (@(posedge clk) disable iff (rst)
		(div_code[0] && div_code > 6'h01 && div_code < 6'h3F)
		|=> (div_ratio == $past(div_code) - 6'h01))
		else $error("odd divide not lowered");
	a_div_mute_zero: assert property (@(posedge clk) disable iff (rst)
		(div_code == 6'h00) |=> out_mute)
		else $error("zero code did not mute");

endmodule // vad_div_decode

// ---- design/vad_aux_drive.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------
// three auxiliary output pins: serial, static, routed, idle
// ----------------------------------------------------------------
module vad_aux_drive (
	input wire logic clk,
	input wire logic rst,
	input wire logic aux_enable,
	input wire logic serial_mode,
	input wire logic [2:0] static_vals,
	input wire logic [1:0] route,
	input wire logic [1:0] idle_mode,
	input wire logic general_output_mux,
	input wire logic spi_sck,
	input wire logic spi_cs,
	input wire logic spi_dout,
	output logic [2:0] aux_out,
	output logic [2:0] aux_oe
);

	logic [2:0] base; // serial or static value
	logic [2:0] next_aux_out; // next pin level
	logic [2:0] next_aux_oe; // next pin enable
	vad_pkg::vad_idle_t idle; // decoded idle drive

	// ----------------------------------------------------------------
	// next pin state
	// ----------------------------------------------------------------
	always_comb begin
		idle = vad_pkg::vad_idle_t'(idle_mode);
		// pin 0 clock, pin 1 select, pin 2 data in serial use
		base = serial_mode ? {spi_dout, spi_cs, spi_sck}
			: static_vals;
		next_aux_out = base;
		next_aux_oe = 3'h7;
		if (route != 2'h0) begin
			// general output replaces one pin in either mode
			next_aux_out[route - 2'h1] = general_output_mux;
		end
		if (!aux_enable) begin
			unique case (idle)
				vad_pkg::IDLE_HIZ: begin
					next_aux_out = 3'h0;
					next_aux_oe = 3'h0;
				end
				vad_pkg::IDLE_KEEP: begin
					// hold whatever was last driven
					next_aux_out = aux_out;
				end
				vad_pkg::IDLE_HIGH: begin
					next_aux_out = 3'h7;
				end
				vad_pkg::IDLE_LOW: begin
					next_aux_out = 3'h0;
				end
			endcase
		end
	end

	// registered pins keep the pads free of decode glitches
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			aux_out <= 3'h0;
			aux_oe <= 3'h0;
		end else begin
			aux_out <= next_aux_out;
			aux_oe <= next_aux_oe;
		end
	end

	a_aux_static_vals: assert property (@(posedge clk) disable iff (rst)
		(aux_enable && !serial_mode && route == 2'h0)
		|=> (aux_out == $past(static_vals) && aux_oe == 3'h7))
		else $error("static value not on pins");
	a_aux_route_pin1: assert property (@(posedge clk) disable iff (rst)
		(aux_enable && route == 2'h2) |=> (aux_out[1] == $past(general_output_mux)))
		else $error("general output not routed to pin 1");
	a_aux_idle_hiz: assert property (@(posedge clk) disable iff (rst)
		(!aux_enable && idle_mode == 2'h0) |=> (aux_oe == 3'h0))
		else $error("disabled pins not released");
	a_aux_idle_high: assert property (@(posedge clk) disable iff (rst)
		(!aux_enable && idle_mode == 2'h2) |=> (aux_out == 3'h7))
		else $error("disabled pins not high");

endmodule // vad_aux_drive

// ---- verif/vad_host_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------
// host controller on the serial control port
// ----------------------------------------------------------------
module vad_host_model (
	input wire logic clk,
	output logic [4:0] reg_addr,
	output logic reg_wr,
	output logic [23:0] reg_wdata,
	output logic reg_rd,
	output logic exact_freq_mode,
	input wire logic [23:0] reg_rdata
);
	// quiet bus from time zero
	initial begin
		reg_addr = 5'h00;
		reg_wr = 1'b0;
		reg_wdata = 24'h00_0000;
		reg_rd = 1'b0;
		exact_freq_mode = 1'b0;
	end

	// one-cycle write strobe, changed only at falling edges
	task automatic write_reg(input logic [4:0] a, input logic [23:0] w);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = w;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
		// released data shows the inverse so a stale word never passes
		reg_wdata = ~w;
	endtask

	// read data lands one edge after the strobe edge and holds
	task automatic read_reg(input logic [4:0] a, output logic [23:0] r);
		@(negedge clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk);
		reg_rd = 1'b0;
		@(negedge clk);
		r = reg_rdata;
	endtask

	// phase sync is only honoured with exact frequency mode on
	task automatic set_exact(input logic on);
		@(negedge clk);
		exact_freq_mode = on;
	endtask
endmodule // vad_host_model

// ---- verif/test_vad_regs.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------
// self-checking bench for the register bank slice
// ----------------------------------------------------------------
module test_vad_regs;
	logic clk = 1'b0, rst = 1'b1;
	logic [4:0] reg_addr;
	logic reg_wr, reg_rd, exact_freq_mode;
	logic [23:0] reg_wdata, reg_rdata;
	logic [7:0] cal_tune_curve = 8'h80; // matches the reset snapshot
	logic cal_busy = 1'b0, cal_err_sign = 1'b0;
	logic [18:0] cal_err_mag = 19'h7_FFFF;
	logic [31:0] gpo_sources = 32'h0000_0000;
	logic lock_detect = 1'b0, aux_enable = 1'b0, chip_en_pin = 1'b0;
	logic aux_spi_sck = 1'b0, aux_spi_cs = 1'b0, aux_spi_dout = 1'b0;
	logic [2:0] aux_out, aux_oe;
	logic aux_3v3_sel, phase_sync_trig, gpo_out, manual_cal_en;
	logic manual_tune_en, cp_autoscale, out_mute, div_stage_max_gain;
	logic [4:0] cap_switch;
	logic [2:0] vco_subband;
	logic [5:0] out_div_ratio;
	logic [1:0] lo1_gain, lo2_gain;
	logic [3:0] lo1_atten_db, lo2_atten_db;
	int error_cnt = 0, comparisons = 0, i, k, c;
	integer seed = 32'hff5f; // fixed so runs repeat
	logic [23:0] d, w14, w15, w16;
	logic [4:0] sel;
	logic [5:0] v;
	logic [7:0] hits;
	logic [4:0] ra [10];
	logic [23:0] rv [10];

	always #10 clk = ~clk; // 50 MHz

	vad_host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rd(reg_rd),
		.exact_freq_mode(exact_freq_mode), .reg_rdata(reg_rdata));

	vad_regs dut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .cal_tune_curve(cal_tune_curve),
		.cal_busy(cal_busy), .cal_err_mag(cal_err_mag),
		.cal_err_sign(cal_err_sign), .gpo_sources(gpo_sources),
		.lock_detect(lock_detect), .aux_spi_sck(aux_spi_sck),
		.aux_spi_cs(aux_spi_cs), .aux_spi_dout(aux_spi_dout),
		.aux_enable(aux_enable), .exact_freq_mode(exact_freq_mode),
		.chip_en_pin(chip_en_pin), .aux_out(aux_out), .aux_oe(aux_oe),
		.aux_3v3_sel(aux_3v3_sel), .phase_sync_trig(phase_sync_trig),
		.gpo_out(gpo_out), .manual_cal_en(manual_cal_en),
		.manual_tune_en(manual_tune_en), .cap_switch(cap_switch),
		.vco_subband(vco_subband), .cp_autoscale(cp_autoscale),
		.out_mute(out_mute), .out_div_ratio(out_div_ratio),
		.lo1_gain(lo1_gain), .lo2_gain(lo2_gain),
		.lo1_atten_db(lo1_atten_db), .lo2_atten_db(lo2_atten_db),
		.div_stage_max_gain(div_stage_max_gain));

	// ----------------------------------------------------------------
	// expectations
	// ----------------------------------------------------------------
	// odd codes above one round down, anything past the top clamps
	function automatic logic [5:0] div_exp(input logic [5:0] cd);
		if (cd > vad_pkg::DIV_MAX) return vad_pkg::DIV_MAX;
		if (cd > 6'h01) return {cd[5:1], 1'b0};
		return cd;
	endfunction

	// three dB per step below the top code
	function automatic logic [3:0] atten(input logic [1:0] g);
		return {2'b00, ~g} * vad_pkg::GAIN_STEP_DB;
	endfunction

	// pin enables and levels as {oe, out}
	function automatic logic [5:0] aux_exp(input logic [23:0] r,
		input logic en, input logic [2:0] ser, input logic g,
		input logic [2:0] last);
		logic [2:0] pv;
		pv = r[0] ? ser : r[3:1];
		if (r[11:10] != 2'b00) pv[r[11:10] - 2'd1] = g;
		if (en) return {3'b111, pv};
		case (r[13:12])
			2'b00: return 6'b000_000;
			2'b01: return {3'b111, last};
			2'b10: return 6'b111_111;
			default: return 6'b111_000;
		endcase
	endfunction

	task automatic check(input string name, input logic [23:0] seen,
		input logic [23:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// every field output against the words last written
	task automatic check_fields(input logic [23:0] m, input logic [23:0] g,
		input logic [23:0] a);
		check("vco", 24'({manual_cal_en, cap_switch, vco_subband, manual_tune_en, cp_autoscale}), 24'({m[0], m[5:1], m[8:6], m[9], m[16]}));
		check("gain", 24'({lo1_gain, lo2_gain, lo1_atten_db, lo2_atten_db, div_stage_max_gain, aux_3v3_sel}), 24'({g[7:6], g[9:8], atten(g[7:6]), atten(g[9:8]), g[10], a[4]}));
		check("div", 24'({out_mute, out_div_ratio}), 24'({g[5:0] == 6'h00, div_exp(g[5:0])}));
	endtask

	task automatic report_and_stop();
		if (error_cnt == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// a hang counts against the run
	initial begin
		#(20 * 50000);
		error_cnt++;
		report_and_stop();
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		ra = '{vad_pkg::A_GPO_SEL, vad_pkg::A_TUNE, vad_pkg::A_CALERR,
			vad_pkg::A_LOCKRB, vad_pkg::A_BUILTIN_TEST, vad_pkg::A_AUX,
			vad_pkg::A_MANVCO, vad_pkg::A_DIVGAIN, 5'h00, 5'h1F};
		rv = '{vad_pkg::RST_GPO_SEL, vad_pkg::RST_TUNE, vad_pkg::RST_CALERR,
			vad_pkg::RST_LOCK_RSVD, vad_pkg::RST_BUILTIN_TEST, vad_pkg::RST_AUX,
			vad_pkg::RST_MANVCO, vad_pkg::RST_DIVGAIN, 24'h00_0000,
			24'h00_0000};
		repeat (4) @(negedge clk);
		rst = 1'b0;
		// reset words, unmapped places read zero
		for (i = 0; i < 10; i++) begin
			host.read_reg(ra[i], d);
			check("reset word", d, rv[i]);
		end
		check_fields(vad_pkg::RST_MANVCO, vad_pkg::RST_DIVGAIN, vad_pkg::RST_AUX);
		// random traffic; first four passes cover every idle and route code
		for (i = 0; i < 24; i++) begin
			@(negedge clk);
			aux_enable = 1'b1;
			{cal_busy, cal_tune_curve} = 9'($random(seed));
			{cal_err_sign, cal_err_mag} = 20'($random(seed));
			gpo_sources = $random(seed);
			lock_detect = 1'($random(seed));
			{aux_spi_dout, aux_spi_cs, aux_spi_sck} = 3'($random(seed));
			w14 = 24'($random(seed));
			w15 = 24'($random(seed));
			w16 = 24'($random(seed));
			sel = 5'($random(seed));
			if (i < 4) begin
				w14[13:10] = {2'(i), 2'(i)};
				w14[0] = i[0];
			end
			host.write_reg(vad_pkg::A_AUX, w14);
			host.write_reg(vad_pkg::A_MANVCO, w15);
			host.write_reg(vad_pkg::A_DIVGAIN, w16);
			host.write_reg(vad_pkg::A_GPO_SEL, {19'h0_0000, sel});
			host.write_reg(5'h10 + 5'(i % 4), ~w15);
			host.write_reg(5'h17 + 5'(i % 9), w15);
			host.read_reg(vad_pkg::A_BUILTIN_TEST, d);
			check("builtin_test", d, vad_pkg::RST_BUILTIN_TEST);
			host.read_reg(vad_pkg::A_AUX, d);
			check("aux reg", d, w14);
			host.read_reg(vad_pkg::A_MANVCO, d);
			check("vco reg", d, w15);
			host.read_reg(vad_pkg::A_DIVGAIN, d);
			check("div reg", d, w16);
			host.read_reg(vad_pkg::A_TUNE, d);
			check("tune", d, {15'h0000, cal_busy, cal_tune_curve});
			host.read_reg(vad_pkg::A_CALERR, d);
			check("cal err", d, {4'h0, cal_err_sign, cal_err_mag});
			host.read_reg(vad_pkg::A_LOCKRB, d);
			check("lock rb", d, vad_pkg::RST_LOCK_RSVD | {22'h00_0000, lock_detect, gpo_sources[sel]});
			host.read_reg(5'h17 + 5'(i % 9), d);
			check("unmapped", d, 24'h00_0000);
			check_fields(w15, w16, w14);
			check("gpo", 24'(gpo_out), 24'(gpo_sources[sel]));
			v = aux_exp(w14, 1'b1, {aux_spi_dout, aux_spi_cs, aux_spi_sck}, gpo_sources[sel], 3'b000);
			check("aux on", 24'({aux_oe, aux_out}), 24'(v));
			// leave the pins or disable them while the serial side moves
			@(negedge clk);
			// first four passes always disable so every idle code shows
			aux_enable = (i < 4) ? 1'b0 : 1'($random(seed));
			{aux_spi_dout, aux_spi_cs, aux_spi_sck} = 3'($random(seed));
			repeat (3) @(negedge clk);
			check("aux off", 24'({aux_oe, aux_out}), 24'(aux_exp(w14, aux_enable, {aux_spi_dout, aux_spi_cs, aux_spi_sck}, gpo_sources[sel], v[2:0])));
		end
		// phase sync needs both the enable bit and exact mode
		for (k = 0; k < 4; k++) begin
			host.write_reg(vad_pkg::A_AUX, {14'h0000, k[0], 9'h000});
			host.set_exact(k[1]);
			repeat (3) @(negedge clk);
			chip_en_pin = 1'b1;
			for (c = 0; c < 8; c++) begin
				@(negedge clk);
				hits[c] = phase_sync_trig;
			end
			chip_en_pin = 1'b0;
			check("sync", 24'($countones(hits)), 24'(k == 3));
		end
		// pin held high across a mid-run reset is no edge; sync bit
		// comes back set and exact mode is still on
		@(negedge clk);
		chip_en_pin = 1'b1;
		rst = 1'b1;
		repeat (4) @(negedge clk);
		rst = 1'b0;
		for (c = 0; c < 8; c++) begin
			@(negedge clk);
			hits[c] = phase_sync_trig;
		end
		chip_en_pin = 1'b0;
		check("sync reset", 24'($countones(hits)), 24'h00_0000);
		w15 = vad_pkg::RST_MANVCO;
		// every divide code, gains at random
		for (c = 0; c < 64; c++) begin
			w16 = {13'h0000, 5'($random(seed)), 6'(c)};
			host.write_reg(vad_pkg::A_DIVGAIN, w16);
			repeat (2) @(negedge clk);
			check_fields(w15, w16, 24'h00_0200);
		end
		report_and_stop();
	end
endmodule // test_vad_regs
